// file: rtl/dsp_pkg.sv
// Purpose: Shared constants for the codec serial statistics port.
// Assumes: One system clock; the codec end makes the bit clock from it.
// Notes:   Both ends and the link checks use these names.
package dsp_pkg;
  localparam int WORD_BITS    = 16;     // Bits in one slot.
  localparam int TX_SLOTS     = 52;     // Slots in a frame sent by the codec.
  localparam int RX_SLOTS     = 84;     // Slots in a frame sent by the processor.
  localparam int CLK_DIV      = 4;      // System clocks per serial bit clock.
  localparam int HALF_DIV     = CLK_DIV / 2; // System clocks per bit clock phase.
  localparam int SYS_CLK_MHZ  = 200;    // System clock rate.
  localparam int MAX_SLOTS    = 128;    // Bound for slot counter width.
  localparam logic [15:0] WORD_ZERO = 16'h0000; // Reset value of a word.
endpackage

// file: rtl/dsp_if.sv
// Purpose: Pins between the codec serial port and the external processor.
// Assumes: All pins are one-way; the bit clock is made by the codec end.
// Notes:   No clocking block; the bench joins the two ends through this.
`timescale 1ns/1ps
`default_nettype none
interface dsp_if;
  logic serial_bit_clock;        // Bit clock driven by the codec.
  logic tx_data;                 // Codec to processor data.
  logic transmit_frame_sync;     // Codec frame marker.
  logic rx_data;                 // Processor to codec data.
  logic receive_frame_sync;      // Processor frame marker.
  logic processor_alert_line_n;  // Active-low alert from the codec.
  modport codec (
    output serial_bit_clock, tx_data, transmit_frame_sync, processor_alert_line_n,
    input  rx_data, receive_frame_sync
  );
  modport proc (
    input  serial_bit_clock, tx_data, transmit_frame_sync, processor_alert_line_n,
    output rx_data, receive_frame_sync
  );
endinterface
`default_nettype wire

// file: rtl/dsp_codec_end.sv
// Purpose: Codec end of the serial statistics port.
// Assumes: The processor on its side.
// Notes:   Words pass through two-entry buffers in each direction.
`timescale 1ns/1ps
`default_nettype none
module dsp_codec_end #(
  parameter int TX_SLOTS = dsp_pkg::TX_SLOTS, // Slots per transmit frame.
  parameter int RX_SLOTS = dsp_pkg::RX_SLOTS  // Slots per receive frame.
) (
  input  wire logic        CLK_SYS,     // System clock, 200 MHz.
  input  wire logic        SYS_RST,     // Synchronous active-high reset.
  input  wire logic        DSP_PRESENT, // High when a processor is attached.
  input  wire logic        TX_START,    // Pulse: begin a statistics frame.
  input  wire logic [15:0] TX_WORD,     // Word to send.
  input  wire logic        TX_VALID,    // TX_WORD is valid.
  output logic             TX_READY,    // Buffer can take a word.
  output logic [15:0]      RX_WORD,     // Received word.
  output logic             RX_VALID,    // RX_WORD is valid.
  input  wire logic        RX_READY,    // User takes a word.
  output logic             BUSY,        // Transfer in progress.
  dsp_if.codec             link         // Pins to the processor.
);
  localparam int SW = $clog2(dsp_pkg::MAX_SLOTS); // Slot counter width.
  localparam int BW = $clog2(dsp_pkg::WORD_BITS); // Bit counter width.
  localparam logic [1:0] DIV_TOP = 2'(dsp_pkg::CLK_DIV - 1); // Divider top.
  localparam logic [1:0] DIV_FALL = 2'(dsp_pkg::HALF_DIV - 1); // Last high phase.
  localparam logic [BW-1:0] BIT_TOP = BW'(dsp_pkg::WORD_BITS - 1); // Last bit.
  localparam logic [SW-1:0] TX_LAST = SW'(TX_SLOTS - 1); // Last send slot.
  localparam logic [SW-1:0] RX_LAST = SW'(RX_SLOTS - 1); // Last receive slot.

  initial begin
    if (TX_SLOTS < 1 || TX_SLOTS > dsp_pkg::MAX_SLOTS || RX_SLOTS < 1 || RX_SLOTS > dsp_pkg::MAX_SLOTS) begin
      $error("Slot counts out of range.");
    end
  end

  // Divider state and bit clock.
  logic [1:0] div_q, div_d;         // System clock phase in a bit period.
  logic       sclk_q, sclk_d;       // Bit clock level.
  logic       rise_en, fall_en;     // Enables at bit clock edges.

  // The divider runs only with a processor attached; the pin stays low otherwise.
  always_comb begin
    div_d  = DSP_PRESENT ? ((div_q == DIV_TOP) ? 2'h0 : div_q + 2'h1) : DIV_TOP;
    sclk_d = DSP_PRESENT && (div_d <= DIV_FALL);
    rise_en = DSP_PRESENT && (div_q == DIV_TOP); // Rising edge comes next.
    fall_en = DSP_PRESENT && (div_q == DIV_FALL); // Falling edge comes next.
  end

  // Registers the divider.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      div_q  <= DIV_TOP;
      sclk_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      sclk_q <= sclk_d;
    end
  end

  // Input synchronisers for the pins from the processor.
  logic [1:0] rxd_s_q, rfs_s_q;     // Two-stage synchronisers.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      rxd_s_q <= 2'h0;
      rfs_s_q <= 2'h0;
    end else begin
      rxd_s_q <= {rxd_s_q[0], link.rx_data};
      rfs_s_q <= {rfs_s_q[0], link.receive_frame_sync};
    end
  end

  // Transmit buffer: two entries.
  logic [15:0] tb_q [2], tb_d [2];  // Entries.
  logic [1:0]  tb_cnt_q, tb_cnt_d;  // Fill level.
  logic        tb_pop;              // Transmitter takes a word.

  // Transmit machine.
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SYNC = 3'b010, TX_SHIFT = 3'b100} dsp_tx_t;
  dsp_tx_t     tx_st_q, tx_st_d;    // Transmit state.
  logic [15:0] tsh_q, tsh_d;        // Transmit shifter.
  logic [BW-1:0] tbit_q, tbit_d;    // Bit within slot.
  logic [SW-1:0] tslot_q, tslot_d;  // Slot within frame.
  logic        tfs_q, tfs_d;        // Frame sync pin.
  logic        start_q, start_d;    // Pending frame request.

  // Sends a sync pulse for one bit, then 16-bit slots, each MSB first.
  always_comb begin
    tx_st_d = tx_st_q;
    tsh_d   = tsh_q;
    tbit_d  = tbit_q;
    tslot_d = tslot_q;
    tfs_d   = tfs_q;
    tb_pop  = 1'b0;
    start_d = start_q | (TX_START & DSP_PRESENT);
    unique case (tx_st_q)
      TX_IDLE: begin
        if (rise_en && start_q) begin
          tfs_d   = 1'b1;
          start_d = TX_START & DSP_PRESENT;
          tx_st_d = TX_SYNC;
        end
      end
      TX_SYNC: begin
        if (rise_en) begin
          tfs_d   = 1'b0;
          tbit_d  = '0;
          tslot_d = '0;
          tb_pop  = (tb_cnt_q != 2'h0);
          tsh_d   = tb_pop ? tb_q[0] : dsp_pkg::WORD_ZERO;
          tx_st_d = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (rise_en) begin
          if (tbit_q != BIT_TOP) begin
            tbit_d = tbit_q + 1'b1;
            tsh_d  = {tsh_q[14:0], 1'b0};
          end else if (tslot_q != TX_LAST) begin
            tbit_d  = '0;
            tslot_d = tslot_q + 1'b1;
            tb_pop  = (tb_cnt_q != 2'h0);
            tsh_d   = tb_pop ? tb_q[0] : dsp_pkg::WORD_ZERO;
          end else begin
            tsh_d   = dsp_pkg::WORD_ZERO;
            tx_st_d = TX_IDLE;
          end
        end
      end
    endcase
  end

  // Transmit buffer next state.
  always_comb begin
    tb_d     = tb_q;
    tb_cnt_d = tb_cnt_q;
    if (tb_pop) begin
      tb_d[0]  = tb_q[1];
      tb_cnt_d = tb_cnt_d - 2'h1;
    end
    if (TX_VALID && TX_READY) begin
      tb_d[tb_cnt_d[0]] = TX_WORD;
      tb_cnt_d = tb_cnt_d + 2'h1;
    end
  end

  // Receive machine.
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_SYNC = 3'b010, RX_SHIFT = 3'b100} dsp_rx_t;
  dsp_rx_t     rx_st_q, rx_st_d;    // Receive state.
  logic [15:0] rsh_q, rsh_d;        // Receive shifter.
  logic [BW-1:0] rbit_q, rbit_d;    // Bit within slot.
  logic [SW-1:0] rslot_q, rslot_d;  // Slot within frame.
  logic        rfs_old_q, rfs_old_d; // Sync level at previous falling edge.
  logic        rpush;               // A whole word arrived.
  logic [15:0] rb_q [2], rb_d [2];  // Receive buffer entries.
  logic [1:0]  rb_cnt_q, rb_cnt_d;  // Receive buffer fill.

  // Samples on falling edges; a low-to-high sync opens a frame one bit later.
  always_comb begin
    rx_st_d   = rx_st_q;
    rsh_d     = rsh_q;
    rbit_d    = rbit_q;
    rslot_d   = rslot_q;
    rfs_old_d = rfs_old_q;
    rpush     = 1'b0;
    if (fall_en) begin
      rfs_old_d = rfs_s_q[1];
      unique case (rx_st_q)
        RX_IDLE: begin
          if (rfs_s_q[1] && !rfs_old_q) begin
            rx_st_d = RX_SYNC;
          end
        end
        RX_SYNC: begin
          rsh_d   = {15'h0000, rxd_s_q[1]};
          rbit_d  = BW'(1);
          rslot_d = '0;
          rx_st_d = RX_SHIFT;
        end
        RX_SHIFT: begin
          rsh_d  = {rsh_q[14:0], rxd_s_q[1]};
          rbit_d = rbit_q + 1'b1;
          if (rbit_q == BIT_TOP) begin
            rpush  = 1'b1; // A word taken when full is dropped.
            rbit_d = '0;
            if (rslot_q == RX_LAST) begin
              rx_st_d = RX_IDLE;
            end else begin
              rslot_d = rslot_q + 1'b1;
            end
          end
        end
      endcase
    end
    if (!DSP_PRESENT) begin
      rx_st_d = RX_IDLE;
    end
  end

  // Receive buffer next state.
  always_comb begin
    rb_d     = rb_q;
    rb_cnt_d = rb_cnt_q;
    if (RX_VALID && RX_READY) begin
      rb_d[0]  = rb_q[1];
      rb_cnt_d = rb_cnt_d - 2'h1;
    end
    if (rpush && rb_cnt_d != 2'h2) begin
      rb_d[rb_cnt_d[0]] = rsh_d;
      rb_cnt_d = rb_cnt_d + 2'h1;
    end
  end

  // Registers both machines, buffers and pins.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tx_st_q <= TX_IDLE;
      tsh_q <= dsp_pkg::WORD_ZERO;
      tbit_q <= '0;
      tslot_q <= '0;
      tfs_q <= 1'b0;
      start_q <= 1'b0;
      tb_q <= '{dsp_pkg::WORD_ZERO, dsp_pkg::WORD_ZERO};
      tb_cnt_q <= 2'h0;
      rx_st_q <= RX_IDLE;
      rsh_q <= dsp_pkg::WORD_ZERO;
      rbit_q <= '0;
      rslot_q <= '0;
      rfs_old_q <= 1'b1;
      rb_q <= '{dsp_pkg::WORD_ZERO, dsp_pkg::WORD_ZERO};
      rb_cnt_q <= 2'h0;
      TX_READY <= 1'b0;
      RX_VALID <= 1'b0;
      RX_WORD <= dsp_pkg::WORD_ZERO;
      BUSY <= 1'b0;
      link.processor_alert_line_n <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tsh_q <= tsh_d;
      tbit_q <= tbit_d;
      tslot_q <= tslot_d;
      tfs_q <= tfs_d;
      start_q <= start_d;
      tb_q <= tb_d;
      tb_cnt_q <= tb_cnt_d;
      rx_st_q <= rx_st_d;
      rsh_q <= rsh_d;
      rbit_q <= rbit_d;
      rslot_q <= rslot_d;
      rfs_old_q <= rfs_old_d;
      rb_q <= rb_d;
      rb_cnt_q <= rb_cnt_d;
      TX_READY <= (tb_cnt_d != 2'h2);
      RX_VALID <= (rb_cnt_d != 2'h0);
      RX_WORD <= rb_d[0];
      BUSY <= (tx_st_d != TX_IDLE) || (rx_st_d != RX_IDLE);
      link.processor_alert_line_n <= !((tx_st_d != TX_IDLE) || (rx_st_d != RX_IDLE));
    end
  end

  assign link.serial_bit_clock    = sclk_q;
  assign link.tx_data             = tsh_q[15];
  assign link.transmit_frame_sync = tfs_q;
endmodule
`default_nettype wire

// file: rtl/dsp_proc_end.sv
// Purpose: Processor end of the serial statistics port.
// Assumes: Bit clock comes from the codec and is sampled here.
// Notes:   Sends one receive frame per PR_START; collects codec words.
`timescale 1ns/1ps
`default_nettype none
module dsp_proc_end #(
  parameter int TX_SLOTS = dsp_pkg::TX_SLOTS, // Slots the codec sends.
  parameter int RX_SLOTS = dsp_pkg::RX_SLOTS  // Slots this end sends.
) (
  input  wire logic        CLK_SYS,   // System clock.
  input  wire logic        SYS_RST,   // Synchronous active-high reset.
  input  wire logic        PR_START,  // Pulse: send a frame.
  input  wire logic [15:0] PR_TX_WORD, // Word to send.
  input  wire logic        PR_TX_VALID, // Word valid.
  output logic             PR_TX_READY, // Buffer has room.
  output logic [15:0]      PR_RX_WORD,  // Word from codec.
  output logic             PR_RX_VALID, // Pulse: word arrived.
  dsp_if.proc              link       // Pins to the codec.
);
  localparam int SW = $clog2(dsp_pkg::MAX_SLOTS); // Slot counter width.
  localparam int BW = $clog2(dsp_pkg::WORD_BITS); // Bit counter width.
  localparam logic [BW-1:0] BIT_TOP = BW'(dsp_pkg::WORD_BITS - 1); // Last bit.
  localparam logic [SW-1:0] LAST = SW'(RX_SLOTS - 1); // Last slot.
  localparam logic [SW-1:0] TX_LAST = SW'(TX_SLOTS - 1); // Last codec slot.

  initial begin
    if (RX_SLOTS < 1 || RX_SLOTS > dsp_pkg::MAX_SLOTS || TX_SLOTS < 1 || TX_SLOTS > dsp_pkg::MAX_SLOTS) begin
      $error("Slot count out of range.");
    end
  end

  // Synchronisers; the external bit clock is sampled, never used as a clock.
  logic [1:0] ck_s_q, td_s_q, tf_s_q; // Two-stage synchronisers.
  logic       ck_old_q;               // Previous synchronised clock.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ck_s_q <= 2'h0;
      td_s_q <= 2'h0;
      tf_s_q <= 2'h0;
      ck_old_q <= 1'b0;
    end else begin
      ck_s_q <= {ck_s_q[0], link.serial_bit_clock};
      td_s_q <= {td_s_q[0], link.tx_data};
      tf_s_q <= {tf_s_q[0], link.transmit_frame_sync};
      ck_old_q <= ck_s_q[1];
    end
  end

  logic rise, fall; // Edges of the codec bit clock.
  always_comb begin
    rise = ck_s_q[1] & ~ck_old_q;
    fall = ~ck_s_q[1] & ck_old_q;
  end

  // Send state.
  logic [15:0]   sh_q, sh_d;        // Send shifter.
  logic [BW-1:0] bit_q, bit_d;      // Send bit index.
  logic [SW-1:0] slot_q, slot_d;    // Send slot index.
  logic [1:0]    ph_q, ph_d;        // 0 idle, 1 sync, 2 data.
  logic          pend_q, pend_d;    // Frame requested.
  logic          rfs_q, rfs_d;      // Frame sync pin.
  logic [15:0]   fb_q [2], fb_d [2]; // Two-entry send buffer.
  logic [1:0]    fc_q, fc_d;        // Send buffer fill.
  logic          pop;               // Shifter takes a word.
  // Collect state.
  logic [15:0]   ch_q, ch_d;        // Collect shifter.
  logic [BW-1:0] cb_q, cb_d;        // Collect bit index.
  logic [SW-1:0] cs_q, cs_d;        // Collect slot index.
  logic          cact_q, cact_d, carm_q, carm_d; // Collecting, sync seen.
  logic          rv_d;              // Word complete.

  // Raises sync for one bit, then drives slots MSB first after rising edges.
  always_comb begin
    sh_d = sh_q; bit_d = bit_q; slot_d = slot_q; ph_d = ph_q;
    rfs_d = rfs_q; pop = 1'b0;
    pend_d = pend_q | PR_START;
    if (rise) begin
      unique case (ph_q)
        2'h0: if (pend_q) begin rfs_d = 1'b1; pend_d = PR_START; ph_d = 2'h1; end
        2'h1: begin
          rfs_d = 1'b0; bit_d = '0; slot_d = '0; ph_d = 2'h2;
          pop = (fc_q != 2'h0);
          sh_d = pop ? fb_q[0] : dsp_pkg::WORD_ZERO;
        end
        2'h2: begin
          if (bit_q != BIT_TOP) begin
            bit_d = bit_q + 1'b1; sh_d = {sh_q[14:0], 1'b0};
          end else if (slot_q != LAST) begin
            bit_d = '0; slot_d = slot_q + 1'b1; pop = (fc_q != 2'h0);
            sh_d = pop ? fb_q[0] : dsp_pkg::WORD_ZERO;
          end else begin
            sh_d = dsp_pkg::WORD_ZERO; ph_d = 2'h0;
          end
        end
        default: ph_d = 2'h0;
      endcase
    end
    fb_d = fb_q; fc_d = fc_q;
    if (pop) begin fb_d[0] = fb_q[1]; fc_d = fc_d - 2'h1; end
    if (PR_TX_VALID && PR_TX_READY) begin fb_d[fc_d[0]] = PR_TX_WORD; fc_d = fc_d + 2'h1; end
    // Collect: sync seen high at a falling edge opens words at the next one.
    ch_d = ch_q; cb_d = cb_q; cs_d = cs_q; cact_d = cact_q; carm_d = carm_q; rv_d = 1'b0;
    if (fall) begin
      if (tf_s_q[1]) begin
        carm_d = 1'b1; cact_d = 1'b0; cs_d = '0;
      end else if (carm_q || cact_q) begin
        carm_d = 1'b0; cact_d = 1'b1;
        ch_d = {ch_q[14:0], td_s_q[1]};
        cb_d = carm_q ? BW'(1) : BW'(cb_q + 1'b1);
        if (!carm_q && cb_q == BIT_TOP) begin
          rv_d = 1'b1; cb_d = '0; cs_d = cs_q + 1'b1;
          if (cs_q == TX_LAST) begin cact_d = 1'b0; cs_d = '0; end
        end
        if (carm_q) begin ch_d = {15'h0000, td_s_q[1]}; end
      end
    end
  end

  // Registers the processor end.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      sh_q <= dsp_pkg::WORD_ZERO; bit_q <= '0; slot_q <= '0; ph_q <= 2'h0;
      pend_q <= 1'b0; rfs_q <= 1'b0; cs_q <= '0;
      fb_q <= '{dsp_pkg::WORD_ZERO, dsp_pkg::WORD_ZERO}; fc_q <= 2'h0;
      ch_q <= dsp_pkg::WORD_ZERO; cb_q <= '0; cact_q <= 1'b0; carm_q <= 1'b0;
      PR_TX_READY <= 1'b0; PR_RX_WORD <= dsp_pkg::WORD_ZERO; PR_RX_VALID <= 1'b0;
    end else begin
      sh_q <= sh_d; bit_q <= bit_d; slot_q <= slot_d; ph_q <= ph_d;
      pend_q <= pend_d; rfs_q <= rfs_d; cs_q <= cs_d;
      fb_q <= fb_d; fc_q <= fc_d;
      ch_q <= ch_d; cb_q <= cb_d; cact_q <= cact_d; carm_q <= carm_d;
      PR_TX_READY <= (fc_d != 2'h2); PR_RX_VALID <= rv_d;
      if (rv_d) begin PR_RX_WORD <= ch_d; end
    end
  end

  assign link.rx_data = sh_q[15];
  assign link.receive_frame_sync = rfs_q;
endmodule
`default_nettype wire

// file: dv/dsp_link_sva.sv
// Purpose: Concurrent checks on the pins between the two serial port ends.
// Assumes: The pins are sampled on the system clock that makes the bit clock.
// Notes:   The bench instantiates this beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module dsp_link_sva #(
  parameter int TX_SLOTS = dsp_pkg::TX_SLOTS, // Slots per codec frame.
  parameter int RX_SLOTS = dsp_pkg::RX_SLOTS  // Slots per processor frame.
) (
  input wire logic CLK_SYS,                // System clock.
  input wire logic SYS_RST,                // Synchronous reset.
  input wire logic serial_bit_clock,       // Bit clock from the codec.
  input wire logic tx_data,                // Codec data line.
  input wire logic transmit_frame_sync,    // Codec frame marker.
  input wire logic rx_data,                // Processor data line.
  input wire logic receive_frame_sync,     // Processor frame marker.
  input wire logic processor_alert_line_n  // Active-low alert.
);
  // Least marker spacing the check allows: one sync bit plus the slots.
  localparam int FRAME_CYC = (1 + TX_SLOTS * dsp_pkg::WORD_BITS) * dsp_pkg::CLK_DIV;
  localparam int MIN_SLOTS = (TX_SLOTS < RX_SLOTS) ? TX_SLOTS : RX_SLOTS; // Shorter frame.
  // Shortest alert span, less sync detect slack.
  localparam int ALERT_MIN = MIN_SLOTS * dsp_pkg::WORD_BITS * dsp_pkg::CLK_DIV - 8;
  logic [15:0] since_sync_q;  // Cycles since the last marker rose.
  logic [15:0] low_cnt_q;     // Cycles the alert has been low.

  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);

  // Counts spacing of markers and length of the alert; both saturate.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      since_sync_q <= 16'hFFFF;
      low_cnt_q    <= 16'h0000;
    end else begin
      since_sync_q <= $rose(transmit_frame_sync) ? 16'h0001 : since_sync_q + 16'(since_sync_q != 16'hFFFF);
      low_cnt_q    <= processor_alert_line_n ? 16'h0000 : low_cnt_q + 16'(low_cnt_q != 16'hFFFF);
    end
  end

  property p_bit_clock_ratio;
    $rose(serial_bit_clock) |=> serial_bit_clock ##1 !serial_bit_clock ##1 !serial_bit_clock;
  endproperty
  property p_data_moves_high;
    $changed(tx_data) |-> serial_bit_clock;
  endproperty
  property p_sync_one_bit;
    $rose(transmit_frame_sync) |-> transmit_frame_sync[*4] ##1 !transmit_frame_sync;
  endproperty
  property p_sync_on_rise;
    $rose(transmit_frame_sync) |-> serial_bit_clock;
  endproperty
  property p_frame_spacing;
    $rose(transmit_frame_sync) |-> since_sync_q >= FRAME_CYC;
  endproperty
  property p_alert_on_sync;
    $rose(transmit_frame_sync) |-> ##[0:8] !processor_alert_line_n;
  endproperty
  property p_alert_span;
    $rose(processor_alert_line_n) |-> low_cnt_q >= ALERT_MIN;
  endproperty
  property p_alert_idle_reset;
    disable iff (1'b0) SYS_RST ##1 SYS_RST |-> processor_alert_line_n;
  endproperty
  property p_rx_sync_width;
    $rose(receive_frame_sync) |-> receive_frame_sync[*4];
  endproperty

  a_bit_clock_ratio: assert property (p_bit_clock_ratio)
    else $error("bit clock ratio wrong");
  a_data_moves_high: assert property (p_data_moves_high)
    else $error("tx data moved in low phase");
  a_sync_one_bit: assert property (p_sync_one_bit)
    else $error("tx marker width wrong");
  a_sync_on_rise: assert property (p_sync_on_rise)
    else $error("tx marker off rising edge");
  a_frame_spacing: assert property (p_frame_spacing)
    else $error("tx markers too close");
  a_alert_on_sync: assert property (p_alert_on_sync)
    else $error("no alert at frame start");
  a_alert_span: assert property (p_alert_span)
    else $error("alert ended early");
  a_alert_idle_reset: assert property (p_alert_idle_reset)
    else $error("alert low in reset");
  a_rx_sync_width: assert property (p_rx_sync_width)
    else $error("rx marker too short");

  c_tx_frame: cover property ($rose(transmit_frame_sync));
  c_rx_frame: cover property ($rose(receive_frame_sync));
  c_rx_bit: cover property ($rose(rx_data));
  c_alert_end: cover property ($rose(processor_alert_line_n));
endmodule
`default_nettype wire

// file: dv/tb.sv
// Purpose: Self-checking bench joining both ends of the serial port.
// Assumes: Two-slot frames in each direction keep the run short.
// Notes:   Words are rebuilt from the pins at each bit clock fall.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int SLOTS = 2;            // Slots per frame both ways.
  logic        CLK_SYS     = 1'b0;     // System clock.
  logic        SYS_RST     = 1'b1;     // Reset, held at start.
  logic        DSP_PRESENT = 1'b0;     // Processor attached.
  logic        TX_START    = 1'b0;     // Codec frame request.
  logic [15:0] TX_WORD     = 16'h0000; // Codec word in.
  logic        TX_VALID    = 1'b0;     // Codec word valid.
  logic        RX_READY    = 1'b0;     // User takes a word.
  logic        PR_START    = 1'b0;     // Processor frame request.
  logic [15:0] PR_TX_WORD  = 16'h0000; // Processor word in.
  logic        PR_TX_VALID = 1'b0;     // Processor word valid.
  logic        TX_READY;               // Codec buffer room.
  logic [15:0] RX_WORD;                // Codec received word.
  logic        RX_VALID;               // Codec word waiting.
  logic        BUSY;                   // Codec frame active.
  logic        PR_TX_READY;            // Processor buffer room.
  logic [15:0] PR_RX_WORD;             // Word at the processor.
  logic        PR_RX_VALID;            // Processor word pulse.
  int          mismatches  = 0;        // Failed comparisons.
  int          n_tests     = 0;        // Comparisons made.
  int          n_sync      = 0;        // Codec markers seen.
  int          tx_bits     = 0;        // Bits left in codec frame.
  int          rx_bits     = 0;        // Bits left in processor frame.
  logic        rfs_prev    = 1'b0;     // Receive marker at last fall.
  logic [15:0] tx_sh;                  // Codec line shifter.
  logic [15:0] rx_sh;                  // Processor line shifter.
  logic [15:0] tx_wire_q[$];           // Words seen on tx_data.
  logic [15:0] rx_wire_q[$];           // Words seen on rx_data.
  logic [15:0] proc_q[$];              // Words the processor got.

  always #2.5 CLK_SYS = ~CLK_SYS;

  dsp_if dsp_if_i ();
  dsp_codec_end #(.TX_SLOTS(SLOTS), .RX_SLOTS(SLOTS)) dsp_codec_end_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .DSP_PRESENT(DSP_PRESENT), .TX_START(TX_START),
    .TX_WORD(TX_WORD), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_WORD(RX_WORD),
    .RX_VALID(RX_VALID), .RX_READY(RX_READY), .BUSY(BUSY), .link(dsp_if_i));
  dsp_proc_end #(.TX_SLOTS(SLOTS), .RX_SLOTS(SLOTS)) dsp_proc_end_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .PR_START(PR_START), .PR_TX_WORD(PR_TX_WORD),
    .PR_TX_VALID(PR_TX_VALID), .PR_TX_READY(PR_TX_READY), .PR_RX_WORD(PR_RX_WORD),
    .PR_RX_VALID(PR_RX_VALID), .link(dsp_if_i));
  dsp_link_sva #(.TX_SLOTS(SLOTS), .RX_SLOTS(SLOTS)) dsp_link_sva_i (
    .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .serial_bit_clock(dsp_if_i.serial_bit_clock),
    .tx_data(dsp_if_i.tx_data), .transmit_frame_sync(dsp_if_i.transmit_frame_sync),
    .rx_data(dsp_if_i.rx_data), .receive_frame_sync(dsp_if_i.receive_frame_sync),
    .processor_alert_line_n(dsp_if_i.processor_alert_line_n));

  // Rebuilds words MSB first; a frame starts one bit after its marker.
  always @(negedge dsp_if_i.serial_bit_clock) begin
    if (tx_bits > 0) begin
      tx_sh = {tx_sh[14:0], dsp_if_i.tx_data};
      tx_bits--;
      if (tx_bits % 16 == 0) tx_wire_q.push_back(tx_sh);
    end else if (dsp_if_i.transmit_frame_sync === 1'b1) begin
      tx_bits = SLOTS * 16;
      n_sync++;
    end
    if (rx_bits > 0) begin
      rx_sh = {rx_sh[14:0], dsp_if_i.rx_data};
      rx_bits--;
      if (rx_bits % 16 == 0) rx_wire_q.push_back(rx_sh);
    end else if (dsp_if_i.receive_frame_sync === 1'b1 && rfs_prev === 1'b0) begin
      rx_bits = SLOTS * 16;
    end
    rfs_prev = dsp_if_i.receive_frame_sync;
  end

  // Collects each word the processor end reports.
  always @(negedge CLK_SYS) begin
    if (PR_RX_VALID === 1'b1) proc_q.push_back(PR_RX_WORD);
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the word until the edge that takes it; to_proc picks the end.
  task automatic push(input bit to_proc, input logic [15:0] w);
    @(negedge CLK_SYS);
    if (to_proc) {PR_TX_WORD, PR_TX_VALID} = {w, 1'b1};
    else {TX_WORD, TX_VALID} = {w, 1'b1};
    while ((to_proc ? PR_TX_READY : TX_READY) !== 1'b1) @(negedge CLK_SYS);
    @(negedge CLK_SYS);
    TX_VALID = 1'b0;
    PR_TX_VALID = 1'b0;
  endtask

  // One-cycle start pulse to the processor end or the codec end.
  task automatic pulse(input bit to_proc);
    @(negedge CLK_SYS);
    if (to_proc) PR_START = 1'b1;
    else TX_START = 1'b1;
    @(negedge CLK_SYS);
    PR_START = 1'b0;
    TX_START = 1'b0;
  endtask

  task automatic pop;
    @(negedge CLK_SYS);
    RX_READY = 1'b1;
    @(negedge CLK_SYS);
    RX_READY = 1'b0;
  endtask

  // Waits for the codec to go idle, with a bound.
  task automatic wait_idle;
    repeat (60) @(negedge CLK_SYS);
    for (int n = 0; BUSY !== 1'b0 && n < 3000; n++) @(negedge CLK_SYS);
    check("busy", 16'(BUSY), 16'h0000);
  endtask

  task automatic t_reset;
    check("tx ready", 16'(TX_READY), 16'h0001);
    check("busy", 16'(BUSY), 16'h0000);
    check("rx valid", 16'(RX_VALID), 16'h0000);
    check("alert", 16'(dsp_if_i.processor_alert_line_n), 16'h0001);
    $display("reset test done");
  endtask

  task automatic t_absent;
    pulse(1'b0);
    repeat (200) @(negedge CLK_SYS);
    check("frames", 16'(n_sync), 16'h0000);
    check("busy", 16'(BUSY), 16'h0000);
    check("alert", 16'(dsp_if_i.processor_alert_line_n), 16'h0001);
    $display("absent test done");
  endtask

  // Two frames back to back; the second has an empty slot.
  task automatic t_tx;
    logic [15:0] exp [4];
    exp = '{16'hA5C3, 16'h8001, 16'h7FFE, 16'h0000};
    DSP_PRESENT = 1'b1;
    repeat (20) @(negedge CLK_SYS);
    push(1'b0, exp[0]);
    push(1'b0, exp[1]);
    check("tx ready full", 16'(TX_READY), 16'h0000);
    pulse(1'b0);
    push(1'b0, exp[2]);
    pulse(1'b0);
    for (int n = 0; proc_q.size() < 4 && n < 3000; n++) @(negedge CLK_SYS);
    wait_idle();
    check("tx words", 16'(tx_wire_q.size()), 16'h0004);
    check("proc words", 16'(proc_q.size()), 16'h0004);
    for (int i = 0; i < 4; i++) begin
      check("tx wire word", tx_wire_q[i], exp[i]);
      check("proc word", proc_q[i], exp[i]);
    end
    check("frames", 16'(n_sync), 16'h0002);
    $display("transmit test done");
  endtask

  // Two frames into a stalled user; the second frame finds the buffer full.
  task automatic t_rx;
    logic [15:0] exp [4];
    exp = '{16'h1234, 16'hFEDC, 16'h0F0F, 16'hF0F0};
    for (int f = 0; f < 2; f++) begin
      push(1'b1, exp[2 * f]);
      push(1'b1, exp[2 * f + 1]);
      pulse(1'b1);
      wait_idle();
    end
    check("rx words", 16'(rx_wire_q.size()), 16'h0004);
    for (int i = 0; i < 4; i++) check("rx wire word", rx_wire_q[i], exp[i]);
    check("rx valid", 16'(RX_VALID), 16'h0001);
    check("rx word", RX_WORD, exp[0]);
    pop();
    check("rx word", RX_WORD, exp[1]);
    pop();
    check("rx valid", 16'(RX_VALID), 16'h0000);
    $display("receive test done");
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge CLK_SYS);
    SYS_RST = 1'b0;
    repeat (2) @(negedge CLK_SYS);
    t_reset();
    t_absent();
    t_tx();
    t_rx();
    summarize();
  end

  // About twenty times the thousand or so cycles the tests need.
  initial begin
    repeat (20000) @(posedge CLK_SYS);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
